// file: inc/nvs_defs.svh
// Overview of operation
// [R1] Erase page chosen by address bit four only
// [R2] Erase needs enable then start, back to back
// [R3] CPU stalled for whole erase cycle
// [R4] Hardware clears erase start when erase ends
// [R5] Erased page words read back zero
// [R6] Software loads data and address before write
// [R7] Write needs enable then start, back to back
// [R8] CPU stalled until write cycle ends
// [R9] Hardware clears write start when write ends
// [R10] Read start with read enable begins read
// [R11] Read end clears start, loads data pair
// [R12] Data pair holds until next operation
// [R13] No address auto increment between reads
// [R14] Software masks interrupts around activation pair
// [R15] No sleep before operation fully completes; the testbench requests sleep in mid write to show the abort
// [R16] Top two control bits select 2/4/8/16 ms
// [R17] Software keeps write enable low when idle
// [R18] Start ignored unless enable already high
// [R19] Software erases page before writing words; the testbench writes word 0x13 without erasing page 1
// [R20] Word bits 7:0 low, 13:8 high register
// [R21] Enable and start never set together; the testbench writes 0x0c with no prior write enable
// [R22] Late start: no erase or write, store unchanged
`ifndef NVS_DEFS_SVH
`define NVS_DEFS_SVH

// Control register bit positions
`define NVS_CTL_TS_HI   7
`define NVS_CTL_TS_LO   6
`define NVS_CTL_ERS_EN  5
`define NVS_CTL_ERS_GO  4
`define NVS_CTL_WR_EN   3
`define NVS_CTL_WR_GO   2
`define NVS_CTL_RD_EN   1
`define NVS_CTL_RD_GO   0

// Reset values
`define NVS_CTL_RST     8'h00
`define NVS_ADDR_RST    5'h00
`define NVS_DATA_RST    14'h0000

// Timing: base program time and clock rate
`define NVS_BASE_TIME_MS 2
`define NVS_CLK_HZ       100000000
`define NVS_BASE_CYCLES  ((`NVS_BASE_TIME_MS * `NVS_CLK_HZ) / 1000)
`define NVS_READ_CYCLES  4

`endif

// file: inc/nvs_pkg.sv
`default_nettype none
package nvs_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    NVS_IDLE,
    NVS_ERASE,
    NVS_WRITE,
    NVS_READ
  } nvs_state_t;
endpackage
`default_nettype wire

// file: logic/nvs_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvs_defs.svh"
// Operation timer: counts base ticks scaled by time select
module nvs_timer
  import nvs_pkg::*;
#(
  parameter int BASE_CYCLES = `NVS_BASE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,     // Load and run
  input  wire logic [4:0] units,     // Base periods to run
  output logic            done       // One-cycle pulse at end
);
  // A zero-length base period would never tick
  if (BASE_CYCLES < 1) begin : g_bad_base
    $error("BASE_CYCLES must be at least 1");
  end

  localparam int CW = $clog2(BASE_CYCLES + 1);

  logic [CW-1:0] tick_cnt_r;  // Cycles within a base period
  logic [4:0]    unit_cnt_r;  // Remaining base periods
  logic          run_r;       // Timer active

  // Divider and period counter share one process for a clean done
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      tick_cnt_r <= '0;
      unit_cnt_r <= '0;
      run_r      <= 1'b0;
    end else if (start) begin
      tick_cnt_r <= '0;
      unit_cnt_r <= units;
      run_r      <= 1'b1;
    end else if (run_r) begin
      if (tick_cnt_r == CW'(BASE_CYCLES - 1)) begin
        tick_cnt_r <= '0;
        // Last period spent: finish
        if (unit_cnt_r == 5'h01) begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end
        unit_cnt_r <= unit_cnt_r - 5'h01;
      end else begin
        tick_cnt_r <= tick_cnt_r + CW'(1);
      end
    end
  end
endmodule // nvs_timer
`default_nettype wire

// file: logic/nvs_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvs_defs.svh"
// Emulated non-volatile word store sequencer
module nvs_seq
  import nvs_pkg::*;
#(
  parameter int WORDS       = 32,
  parameter int PAGE_WORDS  = 16,
  parameter int BASE_CYCLES = `NVS_BASE_CYCLES,
  parameter int READ_CYCLES = `NVS_READ_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // Software write strobes, one per register
  input  wire logic        ADDR_WE,
  input  wire logic        DATA_LO_WE,
  input  wire logic        DATA_HI_WE,
  input  wire logic        CTL_WE,
  input  wire logic [7:0]  WDATA,
  // Register read-back
  output logic      [7:0]  ADDR_Q,
  output logic      [7:0]  DATA_LO_Q,
  output logic      [7:0]  DATA_HI_Q,
  output logic      [7:0]  CTL_Q,
  // CPU hold while an operation runs
  output logic             CPU_STALL,
  // Low-power entry request from core; aborts an operation
  input  wire logic        SLEEP_REQ
);
  // Refuse sizes that the fixed page decode cannot serve
  if (WORDS != 32 || PAGE_WORDS != 16) begin : g_bad_size
    $error("Only 32 words in 16-word pages supported");
  end
  // The read countdown is four bits wide
  if (READ_CYCLES < 1 || READ_CYCLES > 15) begin : g_bad_read
    $error("READ_CYCLES must be 1 to 15");
  end

  logic [13:0]     store [WORDS];     // Word array
  logic [4:0]      word_address_reg;  // Target address
  logic [13:0]     data_reg;          // Data pair, low and high
  logic [7:0]      nv_control_reg;    // Control register
  nvs_state_t      state_r;           // Sequencer state
  logic            en_prev_er_r;      // Erase enable set last cycle
  logic            en_prev_wr_r;      // Write enable set last cycle
  logic [3:0]      rd_cnt_r;          // Read latency count
  logic            tmr_start;
  logic            tmr_done;
  logic [4:0]      tmr_units;
  logic            go_erase;
  logic            go_write;
  logic            go_read;
  logic            end_op;

  // Select time: 1, 2, 4 or 8 base periods
  // A shift keeps the mapping in one place; eight periods still fit in five bits
  function automatic logic [4:0] time_units(input logic [1:0] sel);
    time_units = 5'h01 << sel;
  endfunction

  assign tmr_units = time_units(nv_control_reg[`NVS_CTL_TS_HI:`NVS_CTL_TS_LO]); // [R16]

  // Activation decode: erase or write start needs enable set in the prior cycle
  always_comb begin
    go_erase = 1'b0;
    go_write = 1'b0;
    go_read  = 1'b0;
    if (state_r == NVS_IDLE && CTL_WE) begin
      // Erase or write start only if its enable was written high one cycle earlier; read needs only its enable already set
      go_erase = WDATA[`NVS_CTL_ERS_GO] && en_prev_er_r && nv_control_reg[`NVS_CTL_ERS_EN]; // [R2] [R18] [R22]
      go_write = WDATA[`NVS_CTL_WR_GO] && en_prev_wr_r && nv_control_reg[`NVS_CTL_WR_EN];   // [R7] [R18] [R22]
      go_read  = WDATA[`NVS_CTL_RD_GO] && nv_control_reg[`NVS_CTL_RD_EN];                   // [R10] [R18]
    end
  end

  // Timer runs only for erase and write; reads use the short count
  assign tmr_start = go_erase || go_write;
  // End of operation: timer pulse, or last step of the read count
  assign end_op    = (state_r == NVS_ERASE || state_r == NVS_WRITE) ? tmr_done
                   : (state_r == NVS_READ) && (rd_cnt_r == 4'h1);

  // Stall the CPU for the whole operation; combinational to catch cycle 0
  assign CPU_STALL = (state_r != NVS_IDLE) || go_erase || go_write || go_read; // [R3] [R8] [R10]

  // Back-to-back detector: enable rising-write seen in previous cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      en_prev_er_r <= 1'b0;
      en_prev_wr_r <= 1'b0;
    end else begin
      // Any cycle without an enable write breaks the pair
      // An enable written together with its start counts as no enable
      en_prev_er_r <= CTL_WE && WDATA[`NVS_CTL_ERS_EN] && !WDATA[`NVS_CTL_ERS_GO]; // [R2]
      en_prev_wr_r <= CTL_WE && WDATA[`NVS_CTL_WR_EN] && !WDATA[`NVS_CTL_WR_GO];   // [R7]
    end
  end

  // Sequencer state
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_r  <= NVS_IDLE;
      rd_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        NVS_IDLE: begin
          // Erase wins over write if both were requested at once
          if (go_erase) begin
            state_r <= NVS_ERASE;
          end else if (go_write) begin
            state_r <= NVS_WRITE;
          end else if (go_read) begin
            state_r  <= NVS_READ;
            rd_cnt_r <= 4'(READ_CYCLES);
          end
        end
        NVS_READ: begin
          rd_cnt_r <= rd_cnt_r - 4'h1;
          if (end_op || SLEEP_REQ) begin
            state_r <= NVS_IDLE;
          end
        end
        default: begin
          // Sleep aborts: the operation fails and store is untouched
          if (end_op || SLEEP_REQ) begin // [R15]
            state_r <= NVS_IDLE;
          end
        end
      endcase
    end
  end

  // Store array: changes only at the end of a completed erase or write
  // No reset: the array stands for cells that keep their content
  always_ff @(posedge SYS_CLK) begin
    if (end_op && !SLEEP_REQ) begin
      if (state_r == NVS_ERASE) begin
        for (int i = 0; i < 16; i++) begin
          // Page from bit four; low bits ignored
          store[{word_address_reg[4], 4'(i)}] <= 14'h0000; // [R1] [R5]
        end
      end else if (state_r == NVS_WRITE) begin
        store[word_address_reg] <= data_reg;
      end
    end
  end

  // Address register; never advanced by hardware
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      word_address_reg <= `NVS_ADDR_RST;
    end else if (ADDR_WE && state_r == NVS_IDLE) begin
      word_address_reg <= WDATA[4:0]; // [R13]
    end
  end

  // Data pair: software writes, or read result that then holds
  // Software writes are refused while busy so a running write cannot be torn
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      data_reg <= `NVS_DATA_RST;
    end else if (state_r == NVS_READ && end_op && !SLEEP_REQ) begin
      data_reg <= store[word_address_reg]; // [R11] [R12]
    end else if (state_r == NVS_IDLE) begin
      if (DATA_LO_WE) begin
        data_reg[7:0] <= WDATA; // [R20]
      end
      if (DATA_HI_WE) begin
        data_reg[13:8] <= WDATA[5:0]; // [R20]
      end
    end
  end

  // Control register: software writes, hardware clears on finish
  // Erase and write enables drop too, so a stray start later finds nothing armed
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      nv_control_reg <= `NVS_CTL_RST;
    end else if (state_r != NVS_IDLE) begin
      if (end_op || SLEEP_REQ) begin
        case (state_r)
          NVS_ERASE: begin
            nv_control_reg[`NVS_CTL_ERS_GO] <= 1'b0; // [R4]
            nv_control_reg[`NVS_CTL_ERS_EN] <= 1'b0;
          end
          NVS_WRITE: begin
            nv_control_reg[`NVS_CTL_WR_GO] <= 1'b0; // [R9]
            nv_control_reg[`NVS_CTL_WR_EN] <= 1'b0;
          end
          default: begin
            nv_control_reg[`NVS_CTL_RD_GO] <= 1'b0; // [R11]
          end
        endcase
      end
    end else if (CTL_WE) begin
      nv_control_reg <= WDATA;
      // A start without a valid activation is not kept
      nv_control_reg[`NVS_CTL_ERS_GO] <= go_erase; // [R18]
      nv_control_reg[`NVS_CTL_WR_GO]  <= go_write; // [R18]
      nv_control_reg[`NVS_CTL_RD_GO]  <= go_read;  // [R18]
    end
  end

  // Read-back, unimplemented bits zero
  assign ADDR_Q    = {3'h0, word_address_reg};
  assign DATA_LO_Q = data_reg[7:0];
  assign DATA_HI_Q = {2'h0, data_reg[13:8]};
  assign CTL_Q     = nv_control_reg;

  // Base-period timer; after a sleep abort it runs on, but its late pulse
  // is ignored because end_op only looks at it during erase or write
  nvs_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_timer (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .start (tmr_start),
    .units (tmr_units),
    .done  (tmr_done)
  );
endmodule // nvs_seq
`default_nettype wire

// file: tb/nvs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: issues one register write per cycle, waits out stalls
module nvs_cpu_model
  import nvs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       stall,
  output logic      [3:0] we,     // Strobes: addr, data low, data high, control
  output logic      [7:0] wdata,  // Shared write data
  output logic            sleep   // Low-power entry request
);
  // Quiet bus from time zero
  initial begin
    we = 4'h0;
    wdata = 8'h00;
    sleep = 1'b0;
  end
  // Strobe stays up until the next falling edge so back-to-back writes need no gap
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    we = 4'h1 << sel;
    wdata = d;
    @(negedge clk);
  endtask
  task automatic idle();
    we = 4'h0;
    @(negedge clk);
  endtask
  // Sleep for one cycle; only used to show an abort
  task automatic nap();
    sleep = 1'b1;
    @(negedge clk);
    sleep = 1'b0;
  endtask
  // Address, enable, optional gap, start; n counts stalled cycles, bounded
  task automatic run(input logic [7:0] a, input logic [7:0] en, input logic [7:0] go, input int gap, output int n);
    wr(2'd0, a);
    // Interrupts are taken as masked: nothing runs between enable and start
    wr(2'd3, en);
    repeat (gap) idle();
    wr(2'd3, go);
    idle();
    n = 0;
    while (stall && n < 400) begin
      n++;
      @(negedge clk);
    end
  endtask
endmodule // nvs_cpu_model
`default_nettype wire

// file: tb/nvs_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on stalls, start bits and held registers
module nvs_seq_checker
  import nvs_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RESET_N,
  input wire logic       ADDR_WE,
  input wire logic       DATA_LO_WE,
  input wire logic       DATA_HI_WE,
  input wire logic       CTL_WE,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] ADDR_Q,
  input wire logic [7:0] DATA_LO_Q,
  input wire logic [7:0] DATA_HI_Q,
  input wire logic [7:0] CTL_Q,
  input wire logic       CPU_STALL,
  input wire logic       SLEEP_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // Enable writes by bit, as the pair detector sees them; starts by exact pattern
  wire ers_en = CTL_WE && WDATA[5] && !WDATA[4];
  wire ers_go = CTL_WE && (WDATA[5:0] == 6'h30);
  wire wr_en  = CTL_WE && WDATA[3] && !WDATA[2];
  wire wr_go  = CTL_WE && (WDATA[5:0] == 6'h0c);
  chk_erase_stall: assert property (ers_go && $past(ers_en) && !$past(CPU_STALL) && !SLEEP_REQ
      |-> CPU_STALL ##1 CPU_STALL)
    else $error("valid erase start did not stall");
  chk_write_stall: assert property (wr_go && $past(wr_en) && !$past(CPU_STALL) && !SLEEP_REQ
      |-> CPU_STALL ##1 CPU_STALL)
    else $error("valid write start did not stall");
  chk_erase_late: assert property (ers_go && !$past(ers_en) && !$past(CPU_STALL)
      |-> !CPU_STALL ##1 !CTL_Q[4])
    else $error("late erase start was taken");
  chk_write_late: assert property (wr_go && !$past(wr_en) && !$past(CPU_STALL)
      |-> !CPU_STALL ##1 !CTL_Q[2])
    else $error("late write start was taken");
  chk_stall_length: assert property ($fell(CPU_STALL) && !$past(SLEEP_REQ) && !$past(SLEEP_REQ, 2)
      |-> $past(CPU_STALL, 4))
    else $error("stall ended too early");
  chk_start_clear: assert property ($fell(CPU_STALL) |-> ##[0:1] ((CTL_Q & 8'h15) == 8'h00))
    else $error("start bit still set after stall");
  chk_pad_zero: assert property (DATA_HI_Q[7:6] == 2'b00 && ADDR_Q[7:5] == 3'b000)
    else $error("unused register bits not zero");
  chk_addr_no_inc: assert property (!$past(ADDR_WE) |-> $stable(ADDR_Q))
    else $error("address changed without a write");
  chk_data_hold: assert property (!$past(DATA_LO_WE || DATA_HI_WE || CPU_STALL)
      |-> $stable({DATA_HI_Q, DATA_LO_Q}))
    else $error("data pair changed while idle");
  // Main scenarios reached
  cover property (ers_go && $past(ers_en));
  cover property (SLEEP_REQ && CPU_STALL);
  cover property ($fell(CPU_STALL));
endmodule // nvs_seq_checker
bind nvs_seq nvs_seq_checker u_chk (.SYS_CLK, .RESET_N, .ADDR_WE, .DATA_LO_WE, .DATA_HI_WE, .CTL_WE, .WDATA,
  .ADDR_Q, .DATA_LO_Q, .DATA_HI_Q, .CTL_Q, .CPU_STALL, .SLEEP_REQ);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the sequencer through the core model and checks register views
module testbench;
  localparam int BASE = 10;  // Short base period keeps 16 ms runs small
  localparam int RD   = 4;   // Read latency in cycles
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] we;
  logic [7:0] wdata, addr_q, lo_q, hi_q, ctl_q;
  logic       stall, sleep;
  int         err_count = 0, checked = 0, n;
  always #5 clk = ~clk;
  nvs_cpu_model cpu (.clk(clk), .stall(stall), .we(we), .wdata(wdata), .sleep(sleep));
  nvs_seq #(.BASE_CYCLES(BASE), .READ_CYCLES(RD)) DUT (.SYS_CLK(clk), .RESET_N(rst_n), .ADDR_WE(we[0]),
    .DATA_LO_WE(we[1]), .DATA_HI_WE(we[2]), .CTL_WE(we[3]), .WDATA(wdata), .ADDR_Q(addr_q), .DATA_LO_Q(lo_q),
    .DATA_HI_Q(hi_q), .CTL_Q(ctl_q), .CPU_STALL(stall), .SLEEP_REQ(sleep));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic erase(input logic [7:0] a, input logic [7:0] ts);
    cpu.run(a, ts | 8'h20, ts | 8'h30, 0, n);
  endtask
  // Write stall rounded to base periods must match the time select
  task automatic wword(input logic [7:0] a, input logic [13:0] d, input logic [7:0] ts);
    cpu.wr(2'd1, d[7:0]);
    cpu.wr(2'd2, {2'b00, d[13:8]});
    cpu.run(a, ts | 8'h08, ts | 8'h0c, 0, n);
    cmp(16'((n + 5) / BASE), 16'(1 << ts[7:6]));
  endtask
  // Read leaves the enable set; start must be back at zero
  // Polling starts two cycles after the start write, so RD - 1 polls see the stall
  task automatic rd(input logic [7:0] a, input logic [13:0] e);
    cpu.run(a, 8'h02, 8'h03, 0, n);
    cmp(16'(n), 16'(RD - 1));
    cmp({hi_q, lo_q}, {2'b00, e});
    cmp(16'(ctl_q[0]), 16'h0000);
  endtask
  // Hang guard, far beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    cmp({addr_q, ctl_q}, 16'h0000);
    cmp({hi_q, lo_q}, 16'h0000);
    // Every time select; stalled cycles rounded to base periods
    for (int i = 0; i < 4; i++) begin
      erase(8'h00, 8'(i << 6));
      cmp(16'((n + 5) / BASE), 16'(1 << i));
      cmp(16'(ctl_q), 16'(i << 6));
    end
    wword(8'h03, 14'h2abc, 8'h00);
    cmp(16'(ctl_q), 16'h0000);
    wword(8'h13, 14'h1d35, 8'h40);
    rd(8'h03, 14'h2abc);
    rd(8'h13, 14'h1d35);
    cmp(16'(addr_q), 16'h0013);
    cpu.wr(2'd0, 8'h04);
    cpu.idle();
    cmp({hi_q, lo_q}, 16'h1d35);
    // Low nibble set but page 0 must be the one cleared
    erase(8'h0f, 8'h00);
    rd(8'h03, 14'h0000);
    rd(8'h13, 14'h1d35);
    cpu.wr(2'd1, 8'h55);
    cpu.run(8'h13, 8'h08, 8'h0c, 1, n);
    cmp(16'(n), 16'h0000);
    cpu.run(8'h10, 8'h20, 8'h30, 1, n);
    cmp(16'(n), 16'h0000);
    cpu.run(8'h13, 8'h00, 8'h0c, 0, n);
    cmp(16'(n), 16'h0000);
    cpu.run(8'h13, 8'h00, 8'h01, 0, n);
    cmp(16'(n), 16'h0000);
    rd(8'h13, 14'h1d35);
    // Sleep in mid write: a new low byte is loaded so a landed write would show
    cpu.wr(2'd1, 8'h55);
    fork
      cpu.run(8'h13, 8'h08, 8'h0c, 0, n);
      begin
        repeat (8) @(negedge clk);
        cpu.nap();
      end
    join
    // Five polls see the stall before the nap lands; then it must drop
    cmp(16'(n), 16'h0005);
    cmp(16'(ctl_q), 16'h0000);
    rd(8'h13, 14'h1d35);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
